// *** common/stcs_defs.vh ***
// Register map and field constants of the self-test and clock bank
// Function
// - Wave RAM test control, bits 1:0: 00 keeps it idle, 11 runs it.
// - Data RAM test control, bits 3:2: 00 idle, 11 run; both reset to 0.
// - Wave RAM complete flag, status bit 0, reads 1 once the test is done.
// - Data RAM complete flag, status bit 3, reads 1 once the test is done.
// - Data RAM fail field, status bits 5:4, reads 11 on failure, else 00.
// - Clock select, bits 1:0, picks 1, 2, 4 or 8 MHz and resets to 01.
// - Clock report, bits 5:4, shows the clock in use and resets to 01.
// - Memory error flag, bit 2, sets on error, clears on write 1, resets 0.
`ifndef STCS_DEFS_VH
`define STCS_DEFS_VH
// ----------------------------------------
// Addresses
// ----------------------------------------
`define STCS_ADDR_W 32
`define STCS_ADDR_RAM_SELFTEST_CONTROL 32'h40000502
`define STCS_ADDR_RAM_SELFTEST_STATUS 32'h40000503
`define STCS_ADDR_CPU_FREQUENCY_CONTROL 32'h40000504
`define STCS_ADDR_PROGRAM_MEMORY_STATUS 32'h40000505
`define STCS_DI_PAGE 4'h2
`define STCS_DI_OFS_RAM_SELFTEST_CONTROL 8'h02
`define STCS_DI_OFS_RAM_SELFTEST_STATUS 8'h03
`define STCS_DI_OFS_CPU_FREQUENCY_CONTROL 8'h04
`define STCS_DI_OFS_PROGRAM_MEMORY_STATUS 8'h05
// ----------------------------------------
// Fields
// ----------------------------------------
`define STCS_TEST_IDLE 2'h0
`define STCS_TEST_RUN 2'h3
`define STCS_FAIL_CODE 2'h3
`define STCS_CTRL_RST 2'h0
`define STCS_CLK_RST 2'h1
`define STCS_WAVE_DONE_BIT 0
`define STCS_WAVE_FAIL_BIT 1
`define STCS_DATA_DONE_BIT 3
`define STCS_DATA_FAIL_LSB 4
`define STCS_CLK_REPORT_LSB 4
`define STCS_PM_ERR_BIT 2
`endif

// *** dv/stcs_monitor.sv ***
// Port assertions for the self-test and clock status bank
`timescale 1ns/1ps
module stcs_monitor (
  input wire ref_clk,
  input wire rstn,
  input wire [31:0] cpu_addr,
  input wire cpu_wr,
  input wire di_wr,
  input wire [7:0] cpu_wdata,
  input wire [7:0] cpu_rdata,
  input wire wave_ram_test_run,
  input wire data_ram_test_run,
  input wire [1:0] cpu_clk_select,
  input wire [1:0] cpu_clk_active
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  wire hc = cpu_addr == 32'h40000502;
  wire hs = cpu_addr == 32'h40000503;
  wire hf = cpu_addr == 32'h40000504;
  property p_wrun;
    cpu_wr && hc |=> wave_ram_test_run == ($past(cpu_wdata) % 4 == 3);
  endproperty
  a_wrun: assert property (p_wrun) else $error("wave run");
  property p_drun;
    cpu_wr && hc |=> data_ram_test_run == ($past(cpu_wdata) % 16 > 11);
  endproperty
  a_drun: assert property (p_drun) else $error("data run");
  // Two idle cycles: one to clear the flag, one to read it
  property p_widle;
    (hs && !wave_ram_test_run) [*2] |=> !cpu_rdata[0];
  endproperty
  a_widle: assert property (p_widle) else $error("wave done");
  property p_didle;
    (hs && !data_ram_test_run) [*2] |=> !cpu_rdata[3];
  endproperty
  a_didle: assert property (p_didle) else $error("data done");
  property p_fail;
    hs |=> cpu_rdata[5] == cpu_rdata[4] && (cpu_rdata & 8'hC4) == 8'h00;
  endproperty
  a_fail: assert property (p_fail) else $error("status");
  property p_sel;
    cpu_wr && hf |=> cpu_clk_select == $past(cpu_wdata) % 4;
  endproperty
  a_sel: assert property (p_sel) else $error("clock select");
  property p_rep;
    hf && $past(rstn) && $stable(cpu_clk_active)
      |=> cpu_rdata[5:4] == $past(cpu_clk_active);
  endproperty
  a_rep: assert property (p_rep) else $error("clock report");
  property p_back;
    cpu_wr && hc ##1 hc && !cpu_wr && !di_wr
      |=> cpu_rdata == ($past(cpu_wdata, 2) & 8'h0F);
  endproperty
  a_back: assert property (p_back) else $error("readback");
endmodule // stcs_monitor
bind stcs_regs stcs_monitor u_mon (.ref_clk, .rstn, .cpu_addr, .cpu_wr,
  .di_wr, .cpu_wdata, .cpu_rdata, .wave_ram_test_run, .data_ram_test_run,
  .cpu_clk_select, .cpu_clk_active);

// *** dv/testbench.sv ***
// Self-checking bench for the self-test and clock status bank
`timescale 1ns/1ps
module testbench;
  reg ref_clk = 0, rstn = 0, cpu_wr = 0, di_wr = 0, wd = 0, dd = 0, pe = 0;
  reg [31:0] cpu_addr = 0, seed = 32'h1BA0, b = 32'h40000500;
  reg [7:0] cpu_wdata = 0, di_wdata = 0, di_offset = 0, v;
  reg [3:0] di_page = 0;
  reg [1:0] act = 2'h1;
  wire [7:0] cpu_rdata, di_rdata;
  wire wr_run, dr_run;
  wire [1:0] sel;
  integer n_errors = 0, total_checks = 0, i;
  always #12.5 ref_clk = ~ref_clk;
  stcs_regs u_dut (.ref_clk, .rstn, .cpu_addr, .cpu_wr, .cpu_wdata,
    .cpu_rdata, .di_page, .di_offset, .di_wr, .di_wdata, .di_rdata,
    .wave_engine_done(wd), .wave_engine_fail(i[0]), .data_engine_done(dd),
    .data_engine_fail(i[0]), .wave_ram_test_run(wr_run),
    .data_ram_test_run(dr_run), .cpu_clk_select(sel), .cpu_clk_active(act),
    .program_memory_error(pe));
  function [7:0] sts(input f);
    sts = {2'h0, f, f, 1'b1, 1'b0, f, 1'b1};
  endfunction
  task chk(input string nm, input [7:0] e, g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, d);
    @(negedge ref_clk);
    cpu_addr = b + a;
    cpu_wdata = d;
    cpu_wr = 1;
    @(negedge ref_clk);
    cpu_wr = 0;
  endtask
  task rd(input [7:0] a, e);
    @(negedge ref_clk);
    cpu_addr = b + a;
    @(negedge ref_clk);
    chk("rdata", e, cpu_rdata);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk) rstn = 1;
    rd(8'h02, 8'h00);
    rd(8'h04, 8'h11);
    rd(8'h06, 8'h00);
    // Random codes reach the reserved ones as well
    for (i = 0; i < 6; i = i + 1) begin
      v = $random(seed);
      wr(8'h02, v);
      chk("wave_run", v[1:0] == 2'h3, wr_run);
      chk("data_run", v[3:2] == 2'h3, dr_run);
      rd(8'h02, v & 8'h0F);
    end
    for (i = 0; i < 2; i = i + 1) begin
      wr(8'h02, 8'h0F);
      rd(8'h03, 8'h00);
      wd = 1;
      dd = 1;
      @(negedge ref_clk);
      rd(8'h03, sts(i[0]));
      wd = 0;
      dd = 0;
      wr(8'h02, 8'h00);
      rd(8'h03, 8'h00);
    end
    for (i = 0; i < 4; i = i + 1) begin
      act = i[1:0];
      wr(8'h04, 8'hFC | act);
      chk("select", act, sel);
      rd(8'h04, {2'h0, act, 2'h0, act});
    end
    pe = 1;
    // Error and clearing write in one cycle: the error must win
    wr(8'h05, 8'hFF);
    pe = 0;
    rd(8'h05, 8'h04);
    di_page = 4'h2;
    di_offset = 8'h05;
    @(negedge ref_clk);
    chk("di", 8'h04, di_rdata);
    di_wdata = 8'h04;
    di_wr = 1;
    @(negedge ref_clk) di_wr = 0;
    rd(8'h05, 8'h00);
    stop_test;
  end
endmodule // testbench

// *** rtl/stcs_regs.v ***
// Self-test, CPU clock and program memory status register bank
`timescale 1ns/1ps
`include "stcs_defs.vh"
module stcs_regs (
  input wire ref_clk,
  input wire rstn,
  input wire [31:0] cpu_addr,
  input wire cpu_wr,
  input wire [7:0] cpu_wdata,
  output reg [7:0] cpu_rdata,
  input wire [3:0] di_page,
  input wire [7:0] di_offset,
  input wire di_wr,
  input wire [7:0] di_wdata,
  output reg [7:0] di_rdata,
  input wire wave_engine_done,
  input wire wave_engine_fail,
  input wire data_engine_done,
  input wire data_engine_fail,
  output wire wave_ram_test_run,
  output wire data_ram_test_run,
  output wire [1:0] cpu_clk_select,
  input wire [1:0] cpu_clk_active,
  input wire program_memory_error
);
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function [1:0] stcs_idx_cpu;
    input [31:0] a;
    begin
      stcs_idx_cpu = a[1:0] - 2'h2;
    end
  endfunction

  wire cpu_hit = (cpu_addr >= `STCS_ADDR_RAM_SELFTEST_CONTROL) &&
                 (cpu_addr <= `STCS_ADDR_PROGRAM_MEMORY_STATUS);
  wire di_hit = (di_page == `STCS_DI_PAGE) &&
                (di_offset >= `STCS_DI_OFS_RAM_SELFTEST_CONTROL) &&
                (di_offset <= `STCS_DI_OFS_PROGRAM_MEMORY_STATUS);
  wire [1:0] cpu_idx = stcs_idx_cpu(cpu_addr);
  wire [1:0] di_idx = di_offset[1:0] - 2'h2;
  // Processor bus wins if both ports write in the same cycle
  wire cpu_we = cpu_wr && cpu_hit;
  wire di_we = di_wr && di_hit && !cpu_we;
  wire wr_any = cpu_we || di_we;
  wire [1:0] wr_idx = cpu_we ? cpu_idx : di_idx;
  wire [7:0] wr_data = cpu_we ? cpu_wdata : di_wdata;

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  wire wr_ctrl = wr_any && (wr_idx == 2'h0);
  wire wr_clk = wr_any && (wr_idx == 2'h2);
  wire wr_pm = wr_any && (wr_idx == 2'h3);
  // Only bit 2 of a status write is a clear request
  wire pm_clear = wr_pm && wr_data[`STCS_PM_ERR_BIT];

  // ----------------------------------------
  // Writable state
  // ----------------------------------------
  reg [1:0] wave_ctrl;
  reg [1:0] data_ctrl;
  reg [1:0] clk_sel;
  reg pm_err;
  reg [1:0] clk_report;
  reg [1:0] next_wave_ctrl;
  reg [1:0] next_data_ctrl;
  reg [1:0] next_clk_sel;
  reg next_pm_err;

  // Bits 7:4 are dropped so the reserved bits always read zero
  always @* begin
    next_wave_ctrl = wave_ctrl;
    next_data_ctrl = data_ctrl;
    if (wr_ctrl) begin
      next_wave_ctrl = wr_data[1:0];
      next_data_ctrl = wr_data[3:2];
    end
  end

  // Every select code is legal, so no filtering is needed
  always @* begin
    next_clk_sel = clk_sel;
    if (wr_clk) begin
      next_clk_sel = wr_data[1:0];
    end
  end

  // A new error wins over a clearing write in the same cycle,
  // so software never loses an error that lands during its clear
  always @* begin
    next_pm_err = pm_err;
    if (program_memory_error) begin
      next_pm_err = 1'b1;
    end else if (pm_clear) begin
      next_pm_err = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wave_ctrl <= `STCS_CTRL_RST;
      data_ctrl <= `STCS_CTRL_RST;
      clk_sel <= `STCS_CLK_RST;
      clk_report <= `STCS_CLK_RST;
      pm_err <= 1'b0;
    end else begin
      wave_ctrl <= next_wave_ctrl;
      data_ctrl <= next_data_ctrl;
      clk_sel <= next_clk_sel;
      // One register stage on the active clock code, so it lags a cycle
      clk_report <= cpu_clk_active;
      pm_err <= next_pm_err;
    end
  end

  assign cpu_clk_select = clk_sel;

  // ----------------------------------------
  // Self-test trackers
  // ----------------------------------------
  wire wave_complete;
  wire wave_failed;
  wire data_complete;
  wire data_failed;

  stcs_test_tracker u_wave (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run_code(wave_ctrl),
    .engine_done(wave_engine_done),
    .engine_fail(wave_engine_fail),
    .engine_start(wave_ram_test_run),
    .complete(wave_complete),
    .failed(wave_failed)
  );

  stcs_test_tracker u_data (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run_code(data_ctrl),
    .engine_done(data_engine_done),
    .engine_fail(data_engine_fail),
    .engine_start(data_ram_test_run),
    .complete(data_complete),
    .failed(data_failed)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  function [7:0] stcs_read;
    input [1:0] idx;
    input [1:0] wc;
    input [1:0] dc;
    input wd;
    input wf;
    input dd;
    input df;
    input [1:0] cs;
    input [1:0] cr;
    input pe;
    begin
      case (idx)
        2'h0: stcs_read = {4'h0, dc, wc};
        // The fail field is only meaningful with done set
        2'h1: stcs_read = {2'h0, (df ? `STCS_FAIL_CODE : 2'h0), dd,
                           1'b0, wf, wd};
        2'h2: stcs_read = {2'h0, cr, 2'h0, cs};
        2'h3: stcs_read = {5'h00, pe, 2'h0};
        default: stcs_read = 8'h00;
      endcase
    end
  endfunction

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_rdata <= 8'h00;
      di_rdata <= 8'h00;
    end else begin
      // Unmapped addresses read zero on both ports
      cpu_rdata <= cpu_hit ? stcs_read(cpu_idx,
        wave_ctrl,
        data_ctrl,
        wave_complete,
        wave_failed,
        data_complete,
        data_failed,
        clk_sel,
        clk_report,
        pm_err) : 8'h00;
      di_rdata <= di_hit ? stcs_read(di_idx,
        wave_ctrl,
        data_ctrl,
        wave_complete,
        wave_failed,
        data_complete,
        data_failed,
        clk_sel,
        clk_report,
        pm_err) : 8'h00;
    end
  end
endmodule // stcs_regs

// *** rtl/stcs_test_tracker.v ***
// Tracks one RAM self-test: run command in, complete and fail status out
`timescale 1ns/1ps
`include "stcs_defs.vh"
module stcs_test_tracker (
  input wire ref_clk,
  input wire rstn,
  input wire [1:0] run_code,
  input wire engine_done,
  input wire engine_fail,
  output wire engine_start,
  output reg complete,
  output reg failed
);
  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  // Reserved codes are treated as idle so a stray write cannot start a test
  assign engine_start = (run_code == `STCS_TEST_RUN);

  // ----------------------------------------
  // Status
  // ----------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      complete <= 1'b0;
      failed <= 1'b0;
    end else if (!engine_start) begin
      complete <= 1'b0;
      failed <= 1'b0;
    end else if (engine_done && !complete) begin
      complete <= 1'b1;
      failed <= engine_fail;
    end
  end
endmodule // stcs_test_tracker
